//--- logic/sdd_dev_end.sv
// module: device end, command decode, bank state and data array
`timescale 1ns/100ps
module sdd_dev_end
    import sdd_pkg::*;
#(
    // rows and columns kept in the small backing array
    parameter int MEM_ROW_BITS = 2,
    parameter int MEM_COL_BITS = 4
) (
    // clock and control
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 ce,
    // memory pins
    sdd_pin_if.dev                    pins,
    // observed state
    output logic      [NUM_BANKS-1:0] bank_active,
    output logic      [ADDR_W-1:0]    mode_op,
    output sdd_cmd_e                  last_cmd,
    output logic                      all_precharged
);
    localparam int IDX_W     = BANK_W + MEM_ROW_BITS + MEM_COL_BITS;
    localparam int MEM_DEPTH = 1 << IDX_W;

    sdd_dev_s          s;
    sdd_dev_s          next_s;
    sdd_cmd_e          cmd;
    logic              auto_pre;
    logic [COL_W-1:0]  col;
    logic [IDX_W-1:0]  mem_idx;
    logic              mem_we;
    logic [MASK_W-1:0] mem_be;
    logic [MASK_W-1:0] pin_be;
    logic              bank_open;
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    always_comb begin
        next_s = s;
        // all four strobes taken at the same edge
        cmd = sdd_decode(pins.cs_n, pins.ras_n, pins.cas_n,
                         pins.we_n);
        auto_pre  = pins.addr[AUTO_PRE_BIT];
        col       = pins.addr[COL_W-1:0];
        bank_open = s.bank_act[pins.ba];
        // only low row and column bits reach the array; upper bits alias
        mem_idx = {pins.ba,
                   s.open_row[pins.ba][MEM_ROW_BITS-1:0],
                   col[MEM_COL_BITS-1:0]};
        pin_be = sdd_byte_en(pins.low_byte_mask,
                             pins.high_byte_mask);
        mem_we          = 1'b0;
        mem_be          = '0;
        next_s.rd_oe    = '0;
        next_s.all_pre  = 1'b0;
        next_s.last_cmd = cmd;
        unique case (cmd)
            ROW_OPEN_CMD: begin
                // a bank already open keeps its row
                if (!bank_open) begin
                    next_s.bank_act[pins.ba] = 1'b1;
                    next_s.open_row[pins.ba] = pins.addr;
                end
            end
            ROW_CLOSE_CMD: begin
                if (auto_pre) begin
                    next_s.bank_act = '0;
                    next_s.all_pre  = 1'b1;
                end else begin
                    next_s.bank_act[pins.ba] = 1'b0;
                end
            end
            READ_CMD: begin
                if (bank_open) begin
                    next_s.rd_data = mem[mem_idx];
                    next_s.rd_oe   = pin_be;
                    if (auto_pre) begin
                        next_s.bank_act[pins.ba] = 1'b0;
                    end
                end
            end
            WRITE_CMD: begin
                if (bank_open) begin
                    mem_we = 1'b1;
                    mem_be = pin_be;
                    if (auto_pre) begin
                        next_s.bank_act[pins.ba] = 1'b0;
                    end
                end
            end
            MODE_SET_CMD: begin
                // op-code taken only while every bank is idle
                if (s.bank_act == '0) begin
                    next_s.mode_op = pins.addr;
                end
            end
            NOP_CMD, DESELECT_CMD, REFRESH_CMD, BURST_STOP_CMD: begin
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= DEV_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // array holds no reset; contents are undefined until written
    always_ff @(posedge clk) begin
        if (ce && mem_we) begin
            for (int b = 0; b < MASK_W; b++) begin
                if (mem_be[b]) begin
                    mem[mem_idx][b*BYTE_W +: BYTE_W] <=
                        pins.data_io[b*BYTE_W +: BYTE_W];
                end
            end
        end
    end

    // read data drives the wire for one cycle after the read edge
    assign pins.dev_dq_out = s.rd_data;
    assign pins.dev_dq_oe  = s.rd_oe;
    assign bank_active     = s.bank_act;
    assign mode_op         = s.mode_op;
    assign last_cmd        = s.last_cmd;
    assign all_precharged  = s.all_pre;
endmodule // sdd_dev_end

//--- logic/sdd_pkg.sv
// package: pin widths, command codes, state layouts and decode helpers
// Contract
// - row open latches full row address
// - column from A0-A8, A10 requests autoprecharge
// - row close with A10 high closes all
// - mode set captures op-code from address
// - deselected cycles ignored, select joins code
// - strobes captured together, decoded as combination
// - row open decode activates addressed bank
// - row close decode returns bank idle
// - column access when row strobe high
// - write select high reads, low writes
// - masks gate read drivers and writes
// - data launched and captured on rising edges
package sdd_pkg;
    localparam int DATA_W       = 16;
    localparam int BYTE_W       = 8;
    localparam int MASK_W       = 2;
    localparam int ADDR_W       = 13;
    localparam int ROW_W        = 13;
    localparam int COL_W        = 9;
    localparam int BANK_W       = 2;
    localparam int NUM_BANKS    = 4;
    localparam int AUTO_PRE_BIT = 10;
    localparam int FIFO_DEPTH   = 16;
    // edges from a read being accepted to its data being sampled
    localparam logic [1:0] RD_LAT = 2'h2;

    typedef enum logic [3:0] {
        NOP_CMD,
        DESELECT_CMD,
        ROW_OPEN_CMD,
        ROW_CLOSE_CMD,
        READ_CMD,
        WRITE_CMD,
        MODE_SET_CMD,
        REFRESH_CMD,
        BURST_STOP_CMD
    } sdd_cmd_e;

    typedef struct packed {
        logic [NUM_BANKS-1:0]            bank_act;
        logic [NUM_BANKS-1:0][ROW_W-1:0] open_row;
        logic [ADDR_W-1:0]               mode_op;
        sdd_cmd_e                        last_cmd;
        logic [DATA_W-1:0]               rd_data;
        logic [MASK_W-1:0]               rd_oe;
        logic                            all_pre;
    } sdd_dev_s;

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic [MASK_W-1:0] mask;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe;
        logic [1:0]        rd_stage;
    } sdd_ctl_s;

    localparam sdd_dev_s DEV_RST = '0;
    localparam sdd_ctl_s CTL_RST = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                     we_n: 1'b1, default: '0};

    function automatic sdd_cmd_e sdd_decode(input logic cs_n,
        input logic ras_n, input logic cas_n, input logic we_n);
        sdd_cmd_e c;
        c = NOP_CMD;
        if (cs_n) begin
            c = DESELECT_CMD;
        end else begin
            unique case ({ras_n, cas_n, we_n})
                3'h3: c = ROW_OPEN_CMD;
                3'h2: c = ROW_CLOSE_CMD;
                3'h5: c = READ_CMD;
                3'h4: c = WRITE_CMD;
                3'h0: c = MODE_SET_CMD;
                3'h1: c = REFRESH_CMD;
                3'h6: c = BURST_STOP_CMD;
                3'h7: c = NOP_CMD;
            endcase
        end
        return c;
    endfunction

    // strobes {ras_n, cas_n, we_n} for a command
    function automatic logic [2:0] sdd_encode(input sdd_cmd_e c);
        logic [2:0] s;
        s = 3'h7;
        unique case (c)
            ROW_OPEN_CMD:   s = 3'h3;
            ROW_CLOSE_CMD:  s = 3'h2;
            READ_CMD:       s = 3'h5;
            WRITE_CMD:      s = 3'h4;
            MODE_SET_CMD:   s = 3'h0;
            REFRESH_CMD:    s = 3'h1;
            BURST_STOP_CMD: s = 3'h6;
            default:        s = 3'h7;
        endcase
        return s;
    endfunction

    // per-byte enable: bit 0 low byte, bit 1 high byte
    function automatic logic [MASK_W-1:0] sdd_byte_en(input logic lo_mask,
        input logic hi_mask);
        return {~hi_mask, ~lo_mask};
    endfunction
endpackage

//--- logic/sdd_pin_if.sv
// interface: memory pins between controller and device
`timescale 1ns/100ps
interface sdd_pin_if;
    import sdd_pkg::*;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic              low_byte_mask;
    logic              high_byte_mask;
    logic [DATA_W-1:0] ctl_dq_out;
    logic              ctl_dq_oe;
    logic [DATA_W-1:0] dev_dq_out;
    logic [MASK_W-1:0] dev_dq_oe;
    logic [DATA_W-1:0] data_io;

    // wire level worked out per byte; undriven reads as zero
    assign data_io[BYTE_W-1:0] =
        dev_dq_oe[0] ? dev_dq_out[BYTE_W-1:0] :
        ctl_dq_oe    ? ctl_dq_out[BYTE_W-1:0] : 8'h00;
    assign data_io[DATA_W-1:BYTE_W] =
        dev_dq_oe[1] ? dev_dq_out[DATA_W-1:BYTE_W] :
        ctl_dq_oe    ? ctl_dq_out[DATA_W-1:BYTE_W] : 8'h00;

    modport ctl (output cs_n, ras_n, cas_n, we_n, ba, addr,
                 low_byte_mask, high_byte_mask, ctl_dq_out, ctl_dq_oe,
                 input data_io);
    modport dev (input cs_n, ras_n, cas_n, we_n, ba, addr,
                 low_byte_mask, high_byte_mask, data_io,
                 output dev_dq_out, dev_dq_oe);
endinterface // sdd_pin_if

//--- logic/sdd_fifo.sv
// module: synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module sdd_fifo
    import sdd_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and control
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } sdd_fifo_s;

    sdd_fifo_s        s;
    sdd_fifo_s        next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign in_ready  = (s.count != CW'(DEPTH));
    assign out_valid = (s.count != '0);
    assign out_data  = mem[s.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wr_ptr = ptr_inc(s.wr_ptr);
        end
        if (pop) begin
            next_s.rd_ptr = ptr_inc(s.rd_ptr);
        end
        if (push && !pop) begin
            next_s.count = CW'(s.count + 1'b1);
        end else if (pop && !push) begin
            next_s.count = CW'(s.count - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[s.wr_ptr] <= in_data;
        end
    end
endmodule // sdd_fifo

//--- logic/sdd_ctl_end.sv
// module: controller end, drives command pins and queues read data
`timescale 1ns/100ps
module sdd_ctl_end
    import sdd_pkg::*;
(
    // clock and control
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    // memory pins
    sdd_pin_if.ctl                 pins,
    // command request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  sdd_cmd_e               req_cmd,
    input  wire logic [BANK_W-1:0] req_bank,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [MASK_W-1:0] req_mask,
    // read data out
    output logic                   rd_valid,
    input  wire logic              rd_ready,
    output logic      [DATA_W-1:0] rd_data
);
    sdd_ctl_s s;
    sdd_ctl_s next_s;
    logic     fifo_in_ready;
    logic     fifo_in_valid;

    // one read in flight keeps reserved space honest in the queue
    assign req_ready     = (s.rd_stage == 2'h0) && fifo_in_ready;
    assign fifo_in_valid = (s.rd_stage == RD_LAT);

    always_comb begin
        next_s       = s;
        next_s.cs_n  = 1'b0;
        next_s.ras_n = 1'b1;
        next_s.cas_n = 1'b1;
        next_s.we_n  = 1'b1;
        next_s.dq_oe = 1'b0;
        if (s.rd_stage != 2'h0) begin
            next_s.rd_stage = (s.rd_stage == RD_LAT) ? 2'h0
                            : 2'(s.rd_stage + 1'b1);
        end
        if (req_valid && req_ready) begin
            next_s.cs_n = (req_cmd == DESELECT_CMD);
            {next_s.ras_n, next_s.cas_n, next_s.we_n} = sdd_encode(req_cmd);
            next_s.ba   = req_bank;
            next_s.addr = req_addr;
            next_s.mask = req_mask;
            if (req_cmd == WRITE_CMD) begin
                next_s.dq_out = req_wdata;
                next_s.dq_oe  = 1'b1;
            end
            if (req_cmd == READ_CMD) begin
                next_s.rd_stage = 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= CTL_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign pins.cs_n           = s.cs_n;
    assign pins.ras_n          = s.ras_n;
    assign pins.cas_n          = s.cas_n;
    assign pins.we_n           = s.we_n;
    assign pins.ba             = s.ba;
    assign pins.addr           = s.addr;
    assign pins.low_byte_mask  = s.mask[0];
    assign pins.high_byte_mask = s.mask[1];
    assign pins.ctl_dq_out     = s.dq_out;
    assign pins.ctl_dq_oe      = s.dq_oe;

    sdd_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rd_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (pins.data_io),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );
endmodule // sdd_ctl_end

//--- dv/sdd_pin_assertions.sv
// checker: pin-level relations between controller and device ends
`timescale 1ns/100ps
module sdd_pin_assertions
    import sdd_pkg::*;
(
    // clock and reset
    input wire logic              clk,
    input wire logic              sys_rst,
    // command pins
    input wire logic              cs_n,
    input wire logic              ras_n,
    input wire logic              cas_n,
    input wire logic              we_n,
    input wire logic [BANK_W-1:0] ba,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              low_byte_mask,
    input wire logic              high_byte_mask,
    // data pins
    input wire logic              ctl_dq_oe,
    input wire logic [MASK_W-1:0] dev_dq_oe,
    input wire logic [DATA_W-1:0] data_io
);
    logic [NUM_BANKS-1:0] act;
    logic                 opn;
    logic                 cls;
    logic                 rd;
    logic                 wr;

    assign opn = !cs_n && !ras_n && cas_n && we_n;
    assign cls = !cs_n && !ras_n && cas_n && !we_n;
    assign rd  = !cs_n && ras_n && !cas_n && we_n;
    assign wr  = !cs_n && ras_n && !cas_n && !we_n;

    // bank state rebuilt from the pins, so no device internals are needed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            act <= '0;
        end else if (opn) begin
            act[ba] <= 1'b1;
        end else if (cls && addr[AUTO_PRE_BIT]) begin
            act <= '0;
        end else if (cls || ((rd || wr) && addr[AUTO_PRE_BIT])) begin
            act[ba] <= 1'b0;
        end
    end

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_read_drive_mask: assert property (
        rd && act[ba] |=>
        dev_dq_oe == ~$past({high_byte_mask, low_byte_mask}))
        else $error("read drive enables do not follow byte masks");
    a_read_idle_quiet: assert property (
        rd && !act[ba] |=> dev_dq_oe == 2'h0)
        else $error("read to idle bank drove data");
    a_deselect_ignored: assert property (
        cs_n |=> dev_dq_oe == 2'h0)
        else $error("deselected cycle drove data");
    a_write_no_drive: assert property (
        wr |=> dev_dq_oe == 2'h0)
        else $error("write command drove data");
    a_drive_one_cycle: assert property (
        dev_dq_oe != 2'h0 |=> dev_dq_oe == 2'h0)
        else $error("read data held past one cycle");
    a_drive_has_cause: assert property (
        dev_dq_oe != 2'h0 |-> $past(rd && act[ba]))
        else $error("data driven without a read");
    a_masked_high_zero: assert property (
        rd && act[ba] && high_byte_mask |=> data_io[15:8] == 8'h00)
        else $error("masked high byte reached the bus");
    a_no_bus_fight: assert property (
        !(ctl_dq_oe && dev_dq_oe != 2'h0))
        else $error("both ends drive the data bus");
    a_ctl_drive_write: assert property (
        ctl_dq_oe |-> wr)
        else $error("controller drives data without write");

    cover property (rd && act[ba] && high_byte_mask);
    cover property (rd && !act[ba]);
    cover property (cls && addr[AUTO_PRE_BIT]);
    cover property (wr && addr[AUTO_PRE_BIT]);
endmodule // sdd_pin_assertions

//--- dv/test_sdram_cmd_addr_decode.sv
// testbench: controller and device ends joined over the pin interface
`timescale 1ns/100ps
module test_sdram_cmd_addr_decode
    import sdd_pkg::*;
;
    logic clk, sys_rst, req_valid, req_ready, rd_valid, rd_ready;
    sdd_cmd_e req_cmd, last_cmd;
    logic [BANK_W-1:0] req_bank;
    logic [MASK_W-1:0] req_mask;
    logic [ADDR_W-1:0] req_addr, mode_op;
    logic [DATA_W-1:0] req_wdata, rd_data;
    logic [NUM_BANKS-1:0] bank_active;
    logic all_precharged;
    logic ce;
    int miscompares, checks_done;
    sdd_cmd_e quiet [3] = '{DESELECT_CMD, REFRESH_CMD, BURST_STOP_CMD};

    sdd_pin_if u_sdd_pin_if ();
    sdd_ctl_end u_sdd_ctl_end (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .pins(u_sdd_pin_if.ctl), .req_valid(req_valid),
        .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_mask(req_mask),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
    sdd_dev_end #(.MEM_ROW_BITS(2), .MEM_COL_BITS(4)) u_sdd_dev_end (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .pins(u_sdd_pin_if.dev),
        .bank_active(bank_active), .mode_op(mode_op),
        .last_cmd(last_cmd), .all_precharged(all_precharged));
    sdd_pin_assertions u_sdd_pin_assertions (.clk(clk),
        .sys_rst(sys_rst), .cs_n(u_sdd_pin_if.cs_n),
        .ras_n(u_sdd_pin_if.ras_n), .cas_n(u_sdd_pin_if.cas_n),
        .we_n(u_sdd_pin_if.we_n), .ba(u_sdd_pin_if.ba),
        .addr(u_sdd_pin_if.addr),
        .low_byte_mask(u_sdd_pin_if.low_byte_mask),
        .high_byte_mask(u_sdd_pin_if.high_byte_mask),
        .ctl_dq_oe(u_sdd_pin_if.ctl_dq_oe),
        .dev_dq_oe(u_sdd_pin_if.dev_dq_oe),
        .data_io(u_sdd_pin_if.data_io));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [15:0] wd(input int i);
        return {8'(8'hA0 + i), 8'(8'h50 + i)};
    endfunction

    task automatic chk(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // stays valid until taken; returns at the taking edge
    task automatic send(input sdd_cmd_e c, input int b, input int a,
                        input logic [15:0] d, input logic [1:0] m);
        if (!clk) @(posedge clk);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_bank <= 2'(b);
        req_addr <= 13'(a);
        req_wdata <= d;
        req_mask <= m;
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask

    // waits for the device edge, then settles to mid-cycle
    task automatic look;
        if (!clk) @(posedge clk);
        req_valid <= 1'b0;
        rd_ready <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic pop(input logic [15:0] exp);
        if (!clk) @(posedge clk);
        req_valid <= 1'b0;
        rd_ready <= 1'b1;
        @(negedge clk);
        while (rd_valid !== 1'b1) @(negedge clk);
        chk("rd_data", rd_data, exp);
        @(posedge clk);
    endtask

    task automatic end_of_test;
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        {req_valid, rd_ready, req_bank, req_mask} = '0;
        {req_addr, req_wdata} = '0;
        req_cmd = NOP_CMD;
        {miscompares, checks_done} = '0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk("bank_active", 16'(bank_active), 16'h0000);
        send(MODE_SET_CMD, 0, 'h1A5B, 16'h0000, 2'h0);
        look();
        chk("mode_op", 16'(mode_op), 16'h1A5B);
        for (int b = 0; b < NUM_BANKS; b++) begin
            send(ROW_OPEN_CMD, b, b * 'h0405, 16'h0000, 2'h0);
        end
        look();
        chk("bank_active", 16'(bank_active), 16'h000F);
        chk("last_cmd", 16'(last_cmd), 16'(ROW_OPEN_CMD));
        for (int i = 0; i < 16; i++) begin
            send(WRITE_CMD, 0, i, wd(i), 2'h0);
        end
        send(WRITE_CMD, 0, 1, 16'hFFEE, 2'h1);
        send(WRITE_CMD, 0, 2, 16'hDDCC, 2'h2);
        send(READ_CMD, 0, 1, 16'h0000, 2'h0);
        pop(16'hFF51);
        send(READ_CMD, 0, 2, 16'h0000, 2'h0);
        pop(16'hA2CC);
        send(READ_CMD, 0, 3, 16'h0000, 2'h2);
        pop(16'h0053);
        send(READ_CMD, 0, 4, 16'h0000, 2'h1);
        pop(16'hA400);
        foreach (quiet[k]) begin
            send(quiet[k], 0, 0, 16'h0000, 2'h0);
            look();
            chk("last_cmd", 16'(last_cmd), 16'(quiet[k]));
            chk("bank_active", 16'(bank_active), 16'h000F);
        end
        send(MODE_SET_CMD, 0, 'h0777, 16'h0000, 2'h0);
        look();
        chk("mode_op", 16'(mode_op), 16'h1A5B);
        // fill the read queue with the drain side stalled
        for (int i = 0; i < 16; i++) begin
            send(READ_CMD, 0, i, 16'h0000, 2'h0);
        end
        look();
        repeat (3) @(negedge clk);
        chk("req_ready", 16'(req_ready), 16'h0000);
        for (int i = 0; i < 16; i++) begin
            pop(i == 1 ? 16'hFF51 : i == 2 ? 16'hA2CC : wd(i));
        end
        look();
        chk("rd_valid", 16'(rd_valid), 16'h0000);
        send(WRITE_CMD, 1, 'h0405, 16'h1234, 2'h0);
        look();
        chk("bank_active", 16'(bank_active), 16'h000D);
        send(ROW_OPEN_CMD, 1, 13'h0405, 16'h0000, 2'h0);
        // second open of an open bank must keep row 0x405
        send(ROW_OPEN_CMD, 1, 0, 16'h0000, 2'h0);
        send(READ_CMD, 1, 5, 16'h0000, 2'h0);
        pop(16'h1234);
        send(ROW_CLOSE_CMD, 2, 0, 16'h0000, 2'h0);
        look();
        chk("bank_active", 16'(bank_active), 16'h000B);
        chk("all_precharged", 16'(all_precharged), 16'h0000);
        send(READ_CMD, 2, 0, 16'h0000, 2'h0);
        pop(16'h0000);
        send(ROW_CLOSE_CMD, 1, 'h0400, 16'h0000, 2'h0);
        look();
        chk("all_precharged", 16'(all_precharged), 16'h0001);
        chk("bank_active", 16'(bank_active), 16'h0000);
        // clock enable low: command held on the pins is not decoded
        send(ROW_OPEN_CMD, 0, 0, 16'h0000, 2'h0);
        ce <= 1'b0;
        req_valid <= 1'b0;
        repeat (3) @(negedge clk);
        chk("bank_active", 16'(bank_active), 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        look();
        chk("bank_active", 16'(bank_active), 16'h0001);
        end_of_test();
    end
endmodule // test_sdram_cmd_addr_decode
